// *** bus_slave.sv ***
`include "rtc_cfg.svh"

module bus_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary bus address.
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  input  wire logic [7:0]          rd_data,
  output rtc_pkg::reg_req_type     req,
  output logic                     sda_oe
);
  import rtc_pkg::*;

  logic [2:0]    scl_s_ff, nxt_scl_s, sda_s_ff, nxt_sda_s;
  logic          scl_f_ff, nxt_scl_f, sda_f_ff, nxt_sda_f;
  bus_state_type state_ff, nxt_state;
  logic [3:0]    cnt_ff, nxt_cnt, ptr_ff, nxt_ptr;
  logic [7:0]    sh_ff, nxt_sh;
  logic          rw_ff, nxt_rw, first_ff, nxt_first, oe_ff, nxt_oe, wr_ff, nxt_wr;
  logic [7:0]    wdata_ff, nxt_wdata;
  logic          rise, fall, start, stop;

  // Filters pins, detects bus conditions and walks the byte engine.
  always_comb begin
    nxt_scl_s = {scl_s_ff[1:0], scl_in};
    nxt_sda_s = {sda_s_ff[1:0], sda_in};
    nxt_scl_f = (scl_s_ff[1] == scl_s_ff[2]) ? scl_s_ff[2] : scl_f_ff;
    nxt_sda_f = (sda_s_ff[1] == sda_s_ff[2]) ? sda_s_ff[2] : sda_f_ff;
    rise  = !scl_f_ff && nxt_scl_f;
    fall  = scl_f_ff && !nxt_scl_f;
    start = scl_f_ff && nxt_scl_f && sda_f_ff && !nxt_sda_f;
    stop  = scl_f_ff && nxt_scl_f && !sda_f_ff && nxt_sda_f;
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_ptr   = ptr_ff;
    nxt_sh    = sh_ff;
    nxt_rw    = rw_ff;
    nxt_first = first_ff;
    nxt_oe    = oe_ff;
    nxt_wr    = 1'b0;
    nxt_wdata = wdata_ff;
    if (start) begin
      nxt_state = BUS_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end else if (stop) begin
      nxt_state = BUS_IDLE;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        BUS_ADDR, BUS_WDATA: begin
          if (rise && cnt_ff != 4'h8) begin
            nxt_sh  = {sh_ff[6:0], sda_f_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (fall && cnt_ff == 4'h8) begin
            if (state_ff == BUS_ADDR) begin
              nxt_state = (sh_ff[7:1] == DEV_ADDR) ? BUS_AACK : BUS_IDLE;
              nxt_oe    = (sh_ff[7:1] == DEV_ADDR);
              nxt_rw    = sh_ff[0];
            end else begin
              nxt_state = BUS_WACK;
              nxt_oe    = 1'b1;
              nxt_first = 1'b0;
              if (first_ff) begin
                nxt_ptr = sh_ff[3:0];
              end else begin
                nxt_wr    = 1'b1;
                nxt_wdata = sh_ff;
                nxt_ptr   = ptr_ff + 4'h1;
              end
            end
          end
        end
        BUS_AACK, BUS_RLOAD: begin
          if (fall) begin
            nxt_cnt = 4'h0;
            if (state_ff == BUS_AACK && !rw_ff) begin
              nxt_state = BUS_WDATA;
              nxt_first = 1'b1;
              nxt_oe    = 1'b0;
            end else begin
              nxt_state = BUS_RDATA;
              nxt_sh    = rd_data;
              nxt_oe    = !rd_data[7];
              nxt_cnt   = 4'h1;
            end
          end
        end
        BUS_WACK: begin
          if (fall) begin
            nxt_state = BUS_WDATA;
            nxt_oe    = 1'b0;
            nxt_cnt   = 4'h0;
          end
        end
        BUS_RDATA: begin
          if (fall) begin
            if (cnt_ff == 4'h8) begin
              nxt_state = BUS_RACK;
              nxt_oe    = 1'b0;
              nxt_ptr   = ptr_ff + 4'h1;
            end else begin
              nxt_oe  = !sh_ff[6];
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        BUS_RACK: begin
          if (rise) begin
            nxt_state = sda_f_ff ? BUS_IDLE : BUS_RLOAD;
          end
        end
        default: begin
          nxt_state = BUS_IDLE;
        end
      endcase
    end
  end

  // Registers the engine; reset returns the pointer to zero.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      state_ff <= BUS_IDLE;
      cnt_ff   <= 4'h0;
      ptr_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      rw_ff    <= 1'b0;
      first_ff <= 1'b0;
      oe_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      scl_s_ff <= nxt_scl_s;
      sda_s_ff <= nxt_sda_s;
      scl_f_ff <= nxt_scl_f;
      sda_f_ff <= nxt_sda_f;
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ptr_ff   <= nxt_ptr;
      sh_ff    <= nxt_sh;
      rw_ff    <= nxt_rw;
      first_ff <= nxt_first;
      oe_ff    <= nxt_oe;
      wr_ff    <= nxt_wr;
      wdata_ff <= nxt_wdata;
    end
  end

  // The write strobe carries the pointer value it was taken at.
  assign req.wr      = wr_ff;
  assign req.ptr     = wr_ff ? ptr_ff - 4'h1 : ptr_ff;
  assign req.data    = wdata_ff;
  assign req.reading = rw_ff && state_ff != BUS_IDLE;
  assign sda_oe      = oe_ff;

  a_ptr_reset: assert property (@(posedge clk_sys) !rst_b |=> ptr_ff == 4'h0)
    else $error("pointer not cleared by reset");
  a_ptr_write_inc: assert property (@(posedge clk_sys) disable iff (!rst_b)
    nxt_wr |=> ptr_ff == $past(ptr_ff) + 4'h1)
    else $error("pointer did not advance after a written byte");
  a_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stop |=> !oe_ff && state_ff == BUS_IDLE)
    else $error("stop condition left the data line driven");

endmodule : bus_slave

// *** i2c_host_model.sv ***
module i2c_host_model #(
  parameter int HALF = 12
) (
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles released; the clock is driven high and the pull-up holds the data line high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // Data moves mid-low so the slave never sees it race the clock fall.
  task automatic bit_io(input logic b, output logic got);
    hold(HALF / 2);
    sda_low <= !b;
    hold(HALF / 2);
    scl <= 1'b1;
    hold(HALF);
    got = sda_wire;
    scl <= 1'b0;
  endtask : bit_io

  // Start, also usable as a repeated start after an acknowledge.
  task automatic start_cond();
    hold(HALF / 2);
    sda_low <= 1'b0;
    hold(HALF / 2);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    hold(HALF / 2);
    sda_low <= 1'b1;
    hold(HALF / 2);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask : stop_cond

  // One byte out, most significant bit first, then the slave's answer.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], g);
    end
    bit_io(1'b1, g);
    ack = !g;
  endtask : put_byte

  // One byte in; the last byte of a read is refused to end it.
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, g);
  endtask : get_byte
endmodule : i2c_host_model

// *** rtc_cfg.svh ***
// How it works
// - Halt bit clears divider, stops seconds.
// - Permit bit gates power-on reset override.
// - Level mode: interrupt follows gated timer flag.
// - Pulse mode: gated timer events pulse interrupt.
// - Enabled alarm flag holds interrupt active.
// - Internal reset held while oscillator stopped.
// - Reset reinitialises bus logic and pointer.
// - Reset loads documented control and flag values.
// - Time digit bits keep contents across resets.
// - Seconds bit 7 flags clock integrity lost.
// - Seconds kept as two BCD digits.
// - Minutes kept as two BCD digits.
// - Reads freeze counters; pending carries wait.
// - Pointer increments after every data byte.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register offsets on the two-wire bus.
`define REG_MAIN_CONTROL     4'h0
`define REG_INT_CONTROL      4'h1
`define REG_SECONDS          4'h2
`define REG_MINUTES          4'h3

// Field positions.
`define C1_EXT_TEST_BIT      7
`define C1_STOP_BIT          5
`define C1_PERMIT_BIT        3
`define C2_PULSE_BIT         4
`define C2_AF_BIT            3
`define C2_TF_BIT            2
`define C2_AIE_BIT           1
`define C2_TIE_BIT           0
`define TIME_FLAG_BIT        7

// Reset values and write masks.
`define C1_RESET             8'h08
`define C1_WRITE_MASK        8'hA8
`define C2_RESET             5'h00

// Timing.
`define CLK_PERIOD_NS        100
`define INT_PULSE_NS         1000
`define INT_PULSE_CYCLES     ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtc_control_reset_seconds_minutes_test.sv ***
module rtc_control_reset_seconds_minutes_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst_b, osc_in, osc_running, alarm_event, timer_event;
  logic        scl, sda_low, sda_oe, sda_out, sda_wire, int_pin_out, int_pin_oe;
  logic        clock_output_pin, external_clock_test, reset_override_permit;
  int          n_errors = 0;
  int          n_checks = 0;
  int          sec_m, min_m;
  logic [31:0] seed = 32'h0000_f13c;
  logic [7:0]  rd_q[$];

  // Open-drain data line with pull-up; the device pulls only when it drives a zero.
  assign sda_wire = !(sda_low || (sda_oe && !sda_out));

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Reference time: one second forward, carrying into minutes.
  task automatic model_tick();
    sec_m = (sec_m + 1) % 60;
    if (sec_m == 0) begin
      min_m = (min_m + 1) % 60;
    end
  endtask : model_tick

  task automatic reg_wr(input logic [3:0] ptr, input int n, input logic [7:0] a, b);
    logic ack;
    u_host.start_cond();
    u_host.put_byte(8'h54, ack);
    chk("address ack", 8'h01, 8'(ack));
    u_host.put_byte({4'h0, ptr}, ack);
    u_host.put_byte(a, ack);
    if (n > 1) begin
      u_host.put_byte(b, ack);
    end
    u_host.stop_cond();
  endtask : reg_wr

  task automatic rd(input logic set_ptr, input logic [3:0] ptr, input int n);
    logic       ack;
    logic [7:0] b;
    rd_q.delete();
    u_host.start_cond();
    if (set_ptr) begin
      u_host.put_byte(8'h54, ack);
      u_host.put_byte({4'h0, ptr}, ack);
      u_host.start_cond();
    end
    u_host.put_byte(8'h55, ack);
    chk("read ack", 8'h01, 8'(ack));
    for (int i = 0; i < n; i++) begin
      u_host.get_byte(i == n - 1, b);
      rd_q.push_back(b);
    end
    u_host.stop_cond();
  endtask : rd

  // Oscillator cycles; the clock output must follow each level.
  task automatic osc_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys) osc_in <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("clock_output_pin high", 8'h01, 8'(clock_output_pin));
      osc_in <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk("clock_output_pin low", 8'h00, 8'(clock_output_pin));
    end
    repeat (10) @(posedge clk_sys);
  endtask : osc_edges

  task automatic fire(input logic alarm);
    @(posedge clk_sys);
    alarm_event <= alarm;
    timer_event <= !alarm;
    @(posedge clk_sys);
    alarm_event <= 1'b0;
    timer_event <= 1'b0;
  endtask : fire

  task automatic oe_chk(input logic exp, input int w);
    repeat (w) @(posedge clk_sys);
    chk("interrupt", 8'(exp), 8'(int_pin_oe));
    chk("interrupt level", 8'h00, 8'(int_pin_out));
  endtask : oe_chk

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  rtc_core #(
    .OSC_EDGES_PER_TICK (8)
  ) u_dut (
    .clk_sys               (clk_sys),
    .rst_b                 (rst_b),
    .scl_in                (scl),
    .sda_in                (sda_wire),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .osc_in                (osc_in),
    .osc_running           (osc_running),
    .alarm_event           (alarm_event),
    .timer_event           (timer_event),
    .int_pin_out           (int_pin_out),
    .int_pin_oe            (int_pin_oe),
    .clock_output_pin      (clock_output_pin),
    .external_clock_test   (external_clock_test),
    .reset_override_permit (reset_override_permit)
  );

  i2c_host_model #(
    .HALF (12)
  ) u_host (
    .clk_sys  (clk_sys),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  // Watchdog cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    logic ack;
    rst_b = 1'b0;
    osc_in = 1'b0;
    osc_running = 1'b1;
    alarm_event = 1'b0;
    timer_event = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (30) @(posedge clk_sys);
    rd(1'b0, 4'h0, 4);
    chk("ctl1", 8'h08, rd_q[0]);
    chk("ctl2", 8'h00, rd_q[1]);
    chk("sec flag", 8'h80, rd_q[2] & 8'h80);
    chk("min bit7", 8'h80, rd_q[3] & 8'h80);
    chk("test sel", 8'h00, 8'(external_clock_test));
    chk("permit", 8'h01, 8'(reset_override_permit));
    // Random time, written as a pair, read back as BCD.
    seed = lfsr(seed);
    sec_m = int'(seed[15:0] % 60);
    min_m = int'(seed[31:16] % 60);
    reg_wr(4'h2, 2, bcd(sec_m), bcd(min_m));
    rd(1'b1, 4'h2, 2);
    chk("sec", bcd(sec_m), rd_q[0]);
    chk("min", bcd(min_m), rd_q[1]);
    // Two ticks across the top of the hour digits.
    sec_m = 58;
    min_m = 59;
    reg_wr(4'h2, 2, bcd(sec_m), bcd(min_m));
    repeat (2) begin
      osc_edges(8);
      model_tick();
      rd(1'b1, 4'h2, 2);
      chk("sec tick", bcd(sec_m), rd_q[0]);
      chk("min carry", bcd(min_m), rd_q[1]);
    end
    // Halted divider gives no tick; releasing it resumes counting.
    reg_wr(4'h0, 1, 8'h20, 8'h00);
    osc_edges(8);
    rd(1'b1, 4'h2, 1);
    chk("halted sec", bcd(sec_m), rd_q[0]);
    reg_wr(4'h0, 1, 8'h00, 8'h00);
    chk("permit", 8'h00, 8'(reset_override_permit));
    osc_edges(8);
    model_tick();
    rd(1'b1, 4'h2, 1);
    chk("resumed sec", bcd(sec_m), rd_q[0]);
    // A tick that lands inside a read is held back until the read ends.
    sec_m = 59;
    reg_wr(4'h2, 1, bcd(sec_m), 8'h00);
    fork
      rd(1'b1, 4'h2, 2);
      begin
        repeat (700) @(posedge clk_sys);
        osc_edges(8);
      end
    join
    chk("frozen sec", bcd(sec_m), rd_q[0]);
    chk("frozen min", bcd(min_m), rd_q[1]);
    model_tick();
    rd(1'b1, 4'h2, 2);
    chk("late sec", bcd(sec_m), rd_q[0]);
    chk("late min", bcd(min_m), rd_q[1]);
    // Ones in must-be-zero places are dropped.
    reg_wr(4'h0, 1, 8'hff, 8'h00);
    rd(1'b1, 4'h0, 1);
    chk("masked ctl1", 8'ha8, rd_q[0]);
    chk("test sel", 8'h01, 8'(external_clock_test));
    reg_wr(4'h0, 1, 8'h00, 8'h00);
    // Level mode follows the timer flag until it is cleared.
    reg_wr(4'h1, 1, 8'h01, 8'h00);
    fire(1'b0);
    oe_chk(1'b1, 5);
    oe_chk(1'b1, 20);
    rd(1'b1, 4'h1, 1);
    chk("ctl2 flag", 8'h05, rd_q[0]);
    reg_wr(4'h1, 1, 8'h01, 8'h00);
    oe_chk(1'b0, 2);
    // Pulse mode gives one bounded pulse.
    reg_wr(4'h1, 1, 8'h11, 8'h00);
    fire(1'b0);
    oe_chk(1'b1, 5);
    oe_chk(1'b0, 10);
    // An enabled alarm holds the pin even in pulse mode.
    reg_wr(4'h1, 1, 8'h12, 8'h00);
    fire(1'b1);
    oe_chk(1'b1, 5);
    oe_chk(1'b1, 30);
    reg_wr(4'h1, 1, 8'h10, 8'h00);
    oe_chk(1'b0, 2);
    // A stopped oscillator resets the registers but keeps the digits.
    reg_wr(4'h1, 1, 8'h13, 8'h00);
    osc_running <= 1'b0;
    repeat (20) @(posedge clk_sys);
    osc_running <= 1'b1;
    repeat (30) @(posedge clk_sys);
    rd(1'b0, 4'h0, 4);
    chk("ctl1", 8'h08, rd_q[0]);
    chk("ctl2", 8'h00, rd_q[1]);
    chk("sec kept", 8'h80 | bcd(sec_m), rd_q[2]);
    chk("min kept", 8'h80 | bcd(min_m), rd_q[3]);
    // A foreign address is not acknowledged.
    u_host.start_cond();
    u_host.put_byte(8'h56, ack);
    chk("foreign ack", 8'h00, 8'(ack));
    u_host.stop_cond();
    end_of_test();
  end
endmodule : rtc_control_reset_seconds_minutes_test

// *** rtc_core.sv ***
`include "rtc_cfg.svh"

module rtc_core #(
  parameter int OSC_EDGES_PER_TICK = 32768
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic osc_in,
  input  wire logic osc_running,
  input  wire logic alarm_event,
  input  wire logic timer_event,
  output logic      int_pin_out,
  output logic      int_pin_oe,
  output logic      clock_output_pin,
  output logic      external_clock_test,
  output logic      reset_override_permit
);
  import rtc_pkg::*;

  localparam int DIV_W = $clog2(OSC_EDGES_PER_TICK);

  reg_req_type        req;
  logic [2:0]         osc_s_ff, nxt_osc_s, run_s_ff, nxt_run_s;
  logic               osc_f_ff, nxt_osc_f, run_f_ff, nxt_run_f;
  logic               int_rst_ff, nxt_int_rst, rst_now;
  logic [DIV_W-1:0]   div_ff, nxt_div;
  logic               pend_ff, nxt_pend, tick;
  logic [7:0]         c1_ff, nxt_c1, sec_ff, nxt_sec, min_ff, nxt_min, rd_ff, nxt_rd;
  logic [4:0]         c2_ff, nxt_c2;
  logic [7:0]         pulse_ff, nxt_pulse;
  logic               int_oe_ff, nxt_int_oe, level;
  logic [7:0]         inc_sec, inc_min;

  // Advances a two-digit BCD value 00..59; bit 7 of the result is the carry.
  function automatic logic [7:0] bcd_inc(input logic [6:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (v[3:0] != 4'h9) begin
      r = {1'b0, v[6:4], v[3:0] + 4'h1};
    end else if (v[6:4] != 3'h5) begin
      r = {1'b0, v[6:4] + 3'h1, 4'h0};
    end else begin
      r = 8'h80;
    end
    return r;
  endfunction : bcd_inc

  bus_slave u_bus (
    .clk_sys (clk_sys),
    .rst_b   (!int_rst_ff && rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .rd_data (rd_ff),
    .req     (req),
    .sda_oe  (sda_oe)
  );

  // Oscillator and run-detect synchronisers plus the internal reset.
  always_comb begin
    nxt_osc_s   = {osc_s_ff[1:0], osc_in};
    nxt_run_s   = {run_s_ff[1:0], osc_running};
    nxt_osc_f   = (osc_s_ff[1] == osc_s_ff[2]) ? osc_s_ff[2] : osc_f_ff;
    nxt_run_f   = (run_s_ff[1] == run_s_ff[2]) ? run_s_ff[2] : run_f_ff;
    nxt_int_rst = !run_f_ff;
    rst_now     = !rst_b || int_rst_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      osc_s_ff   <= 3'h0;
      run_s_ff   <= 3'h0;
      osc_f_ff   <= 1'b0;
      run_f_ff   <= 1'b0;
      int_rst_ff <= 1'b1;
    end else begin
      osc_s_ff   <= nxt_osc_s;
      run_s_ff   <= nxt_run_s;
      osc_f_ff   <= nxt_osc_f;
      run_f_ff   <= nxt_run_f;
      int_rst_ff <= nxt_int_rst;
    end
  end

  // Divider, frozen carries, time counters and control registers.
  always_comb begin
    inc_sec = bcd_inc(sec_ff[6:0]);
    inc_min = bcd_inc(min_ff[6:0]);
    tick    = 1'b0;
    nxt_div = div_ff;
    nxt_pend = pend_ff;
    nxt_c1  = c1_ff;
    nxt_c2  = c2_ff;
    nxt_sec = sec_ff;
    nxt_min = min_ff;
    if (c1_ff[`C1_STOP_BIT]) begin
      nxt_div  = '0;
      nxt_pend = 1'b0;
    end else if (!osc_f_ff && nxt_osc_f) begin
      if (div_ff == DIV_W'(OSC_EDGES_PER_TICK - 1)) begin
        nxt_div = '0;
        tick    = 1'b1;
      end else begin
        nxt_div = div_ff + DIV_W'(1);
      end
    end
    if (!c1_ff[`C1_STOP_BIT] && (tick || pend_ff)) begin
      if (req.reading) begin
        nxt_pend = 1'b1;
      end else begin
        nxt_pend = 1'b0;
        nxt_sec  = {sec_ff[`TIME_FLAG_BIT], inc_sec[6:0]};
        if (inc_sec[7]) begin
          nxt_min = {min_ff[7], inc_min[6:0]};
        end
      end
    end
    if (req.wr) begin
      case (req.ptr)
        `REG_MAIN_CONTROL: nxt_c1 = req.data & `C1_WRITE_MASK;
        `REG_INT_CONTROL: begin
          nxt_c2 = req.data[4:0];
          nxt_c2[`C2_AF_BIT] = req.data[`C2_AF_BIT] & c2_ff[`C2_AF_BIT];
          nxt_c2[`C2_TF_BIT] = req.data[`C2_TF_BIT] & c2_ff[`C2_TF_BIT];
        end
        `REG_SECONDS: nxt_sec = req.data;
        `REG_MINUTES: nxt_min = req.data;
        default: nxt_c1 = c1_ff;
      endcase
    end
    if (alarm_event) begin
      nxt_c2[`C2_AF_BIT] = 1'b1;
    end
    if (timer_event) begin
      nxt_c2[`C2_TF_BIT] = 1'b1;
    end
    if (rst_now) begin
      nxt_div  = '0;
      nxt_pend = 1'b0;
      nxt_c1   = `C1_RESET;
      nxt_c2   = `C2_RESET;
      nxt_sec[`TIME_FLAG_BIT] = 1'b1;
      nxt_min[`TIME_FLAG_BIT] = 1'b1;
    end
  end

  // Timekeeping registers; digit bits are left alone by reset.
  always_ff @(posedge clk_sys) begin
    div_ff  <= nxt_div;
    pend_ff <= nxt_pend;
    c1_ff   <= nxt_c1;
    c2_ff   <= nxt_c2;
    sec_ff  <= nxt_sec;
    min_ff  <= nxt_min;
  end

  // Interrupt drive, read data and pin outputs.
  always_comb begin
    level = (c2_ff[`C2_TF_BIT] && c2_ff[`C2_TIE_BIT] && !c2_ff[`C2_PULSE_BIT]) ||
            (c2_ff[`C2_AF_BIT] && c2_ff[`C2_AIE_BIT]);
    nxt_pulse = (pulse_ff != 8'h00) ? pulse_ff - 8'h01 : 8'h00;
    if (timer_event && c2_ff[`C2_TIE_BIT] && c2_ff[`C2_PULSE_BIT]) begin
      nxt_pulse = 8'(`INT_PULSE_CYCLES);
    end
    nxt_int_oe = level || pulse_ff != 8'h00;
    case (req.ptr)
      `REG_MAIN_CONTROL: nxt_rd = c1_ff;
      `REG_INT_CONTROL:  nxt_rd = {3'h0, c2_ff};
      `REG_SECONDS:      nxt_rd = sec_ff;
      `REG_MINUTES:      nxt_rd = min_ff;
      default:           nxt_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst_now) begin
      pulse_ff              <= 8'h00;
      int_oe_ff             <= 1'b0;
      rd_ff                 <= 8'h00;
      clock_output_pin      <= 1'b0;
      external_clock_test   <= 1'b0;
      reset_override_permit <= 1'b1;
    end else begin
      pulse_ff              <= nxt_pulse;
      int_oe_ff             <= nxt_int_oe;
      rd_ff                 <= nxt_rd;
      clock_output_pin      <= osc_f_ff;
      external_clock_test   <= c1_ff[`C1_EXT_TEST_BIT];
      reset_override_permit <= c1_ff[`C1_PERMIT_BIT];
    end
  end

  // Open-drain pins only ever pull low.
  always_ff @(posedge clk_sys) begin
    sda_out     <= 1'b0;
    int_pin_out <= 1'b0;
  end

  assign int_pin_oe = int_oe_ff;

  a_stop_freezes: assert property (@(posedge clk_sys) disable iff (rst_now)
    c1_ff[`C1_STOP_BIT] && !req.wr |=> $stable(sec_ff[6:0]) && div_ff == '0)
    else $error("seconds or divider moved while halted");
  a_level_irq: assert property (@(posedge clk_sys) disable iff (rst_now)
    c2_ff[`C2_TF_BIT] && c2_ff[`C2_TIE_BIT] && !c2_ff[`C2_PULSE_BIT] |=> int_pin_oe)
    else $error("timer level interrupt not driven");
  a_alarm_holds: assert property (@(posedge clk_sys) disable iff (rst_now)
    c2_ff[`C2_AF_BIT] && c2_ff[`C2_AIE_BIT] |=> int_pin_oe)
    else $error("alarm interrupt not held active");
  a_pulse_irq: assert property (@(posedge clk_sys) disable iff (rst_now)
    timer_event && c2_ff[`C2_TIE_BIT] && c2_ff[`C2_PULSE_BIT] |=> ##1 int_pin_oe)
    else $error("timer pulse missing");
  a_reset_loads: assert property (@(posedge clk_sys) rst_now |=>
    c1_ff == `C1_RESET && c2_ff == `C2_RESET && sec_ff[7] && min_ff[7])
    else $error("reset values not loaded");
  a_read_freeze: assert property (@(posedge clk_sys) disable iff (rst_now)
    req.reading && !req.wr |=> $stable(sec_ff[6:0]) && $stable(min_ff[6:0]))
    else $error("time counters moved during a read");
  a_osc_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !run_f_ff |=> int_rst_ff)
    else $error("internal reset released with oscillator stopped");

endmodule : rtc_core

// *** rtc_pkg.sv ***
package rtc_pkg;

  // Byte engine states of the bus slave.
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b000,
    BUS_ADDR  = 3'b001,
    BUS_AACK  = 3'b010,
    BUS_WDATA = 3'b011,
    BUS_WACK  = 3'b100,
    BUS_RDATA = 3'b101,
    BUS_RACK  = 3'b110,
    BUS_RLOAD = 3'b111
  } bus_state_type;

  // Register request from the bus slave to the register file.
  typedef struct packed {
    logic       wr;
    logic [3:0] ptr;
    logic [7:0] data;
    logic       reading;
  } reg_req_type;

endpackage : rtc_pkg
